// ---- shared/hrx_pkg.sv ----
// package: constants and carrier types for the hdlc receive processor
`default_nettype none
package hrx_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SIZE = 8'h04;
    localparam logic [7:0] ADDR_STAT = 8'h08;
    localparam logic [7:0] ADDR_CABT = 8'h0c;
    localparam logic [7:0] ADDR_CSIZ = 8'h10;
    localparam logic [7:0] ADDR_CFCS = 8'h14;
    localparam logic [7:0] ADDR_CGOOD = 8'h18;
    // control fields
    localparam int CTRL_CC = 0;
    localparam int CTRL_DSCR = 1;
    localparam int CTRL_FCS = 2;
    localparam int CTRL_FCS32 = 3;
    localparam int CTRL_XTRC = 4;
    localparam int CTRL_REORD = 5;
    localparam logic [31:0] CTRL_MASK = 32'h0000_003f;
    localparam logic [31:0] CTRL_RST = 32'h0000_0016;
    // size fields: minimum low half, maximum high half
    localparam int SIZE_MIN_LSB = 0;
    localparam int SIZE_MAX_LSB = 16;
    localparam logic [31:0] SIZE_RST = 32'h0600_0004;
    // framing
    localparam logic [7:0] FLAG_PAT = 8'h7e;
    localparam logic [4:0] GAP_MIN = 5'h17;
    localparam logic [4:0] FILL_WIN = 5'h10;
    localparam logic [2:0] DLY_N = 3'h7;
    // fcs
    localparam logic [15:0] CRC16_POLY = 16'h8408;
    localparam logic [31:0] CRC32_POLY = 32'hedb8_8320;
    localparam logic [15:0] CRC16_GOOD = 16'hf0b8;
    localparam logic [31:0] CRC32_GOOD = 32'hdebb_20e3;

    typedef enum logic {HRX_HUNT, HRX_OPEN} hrx_frame_type;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } hrx_apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } hrx_apb_rsp_type;

    // mod holds valid bytes minus one
    typedef struct packed {
        logic [31:0] data;
        logic        sop;
        logic        eop;
        logic        abort;
        logic [1:0]  mod;
    } hrx_word_type;
endpackage
`default_nettype wire

// ---- logic/hrx_sat_cnt.sv ----
// saturating statistics counter with clear
`default_nettype none
module hrx_sat_cnt #(
    parameter int unsigned CNT_W = 16
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             rst,
    // control
    input  wire logic             inc,
    input  wire logic             clr,
    // value
    output logic [CNT_W-1:0]      count
);
    typedef struct packed {
        logic [CNT_W-1:0] count;
    } hrx_cnt_type;

    hrx_cnt_type s;
    hrx_cnt_type n;

    if (CNT_W < 1 || CNT_W > 32) begin : g_bad
        $error("hrx_sat_cnt: CNT_W must be 1 to 32");
    end

    // clear then increment in one cycle gives one, stop at all ones
    always_comb begin
        n = s;
        if (clr) begin
            n.count = '0;
        end
        if (inc && !(&n.count)) begin
            n.count = n.count + 1'b1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign count = s.count;

    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    chk_cnt_hold: assert property ((&s.count) && !clr |=> &s.count)
        else $error("counter wrapped from full");
    chk_cnt_step: assert property (inc && !clr && !(&s.count) |=> s.count == CNT_W'($past(s.count) + 1'b1))
        else $error("counter missed an increment");
endmodule
`default_nettype wire

// ---- logic/hrx_rx_proc.sv ----
// receive hdlc packet processor: serial bits in, tagged 32-bit words out
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`default_nettype none
module hrx_rx_proc #(
    parameter int unsigned CNT_W = 16
) (
    // clock and reset
    input  wire logic                     clock,
    input  wire logic                     rst,
    // serial stream
    input  wire logic                     rx_bit,
    input  wire logic                     rx_bit_valid,
    // register bus
    input  wire hrx_pkg::hrx_apb_req_type apb_req,
    output hrx_pkg::hrx_apb_rsp_type      apb_rsp,
    // receive fifo side
    output hrx_pkg::hrx_word_type         rx_fifo_word,
    output logic                          rx_fifo_valid
);
    typedef struct packed {
        hrx_pkg::hrx_frame_type st;
        logic [42:0]            scr;
        logic [7:0]             hist;
        logic [2:0]             ones;
        logic [4:0]             gap;
        logic [6:0]             dly;
        logic [2:0]             dly_n;
        logic [7:0]             sh;
        logic [2:0]             nbit;
        logic [15:0]            nbyte;
        logic [31:0]            crc;
        logic [31:0]            hold;
        logic [2:0]             hold_n;
        logic [31:0]            acc;
        logic [2:0]             acc_n;
        logic                   sop_due;
        hrx_pkg::hrx_word_type  out;
        logic                   out_v;
        logic [31:0]            ctrl;
        logic [31:0]            size;
        logic [31:0]            rdata;
    } hrx_core_type;

    hrx_core_type s;
    hrx_core_type n;

    if (CNT_W < 1 || CNT_W > 32) begin : g_bad
        $error("hrx_rx_proc: CNT_W must be 1 to 32");
    end

    logic             cc;
    logic             fcs_on;
    logic             fcs32;
    logic [2:0]       fcs_len;
    logic [15:0]      min_len;
    logic [15:0]      max_len;
    logic             d;
    logic [7:0]       win;
    logic             is_flag;
    logic             is_seven;
    logic             is_stuff;
    logic             dbit_v;
    logic             dbit;
    logic             byte_v;
    logic [7:0]       byte_val;
    logic             rel;
    logic [7:0]       rel_byte;
    logic             rel_last;
    logic             end_v;
    logic             end_ab;
    logic             inc_ab;
    logic             inc_sz;
    logic             inc_fcs;
    logic             inc_good;
    logic             wr;
    logic             hit;
    logic [31:0]      rd_mux;
    logic [CNT_W-1:0] cnt_ab;
    logic [CNT_W-1:0] cnt_sz;
    logic [CNT_W-1:0] cnt_fcs;
    logic [CNT_W-1:0] cnt_good;

    // one reflected crc step, 16-bit form kept in the low half
    function automatic logic [31:0] crc_step(input logic [31:0] c, input logic x, input logic w32);
        logic        fb;
        logic [31:0] r;
        fb = c[0] ^ x;
        r = {1'b0, c[31:1]};
        if (w32) begin
            r = r ^ (fb ? hrx_pkg::CRC32_POLY : 32'h0000_0000);
        end else begin
            r = {16'h0000, {1'b0, c[15:1]} ^ (fb ? hrx_pkg::CRC16_POLY : 16'h0000)};
        end
        return r;
    endfunction

    // configuration views
    assign cc = s.ctrl[hrx_pkg::CTRL_CC];
    assign fcs_on = s.ctrl[hrx_pkg::CTRL_FCS];
    assign fcs32 = s.ctrl[hrx_pkg::CTRL_FCS32];
    assign min_len = s.size[hrx_pkg::SIZE_MIN_LSB +: 16];
    assign max_len = s.size[hrx_pkg::SIZE_MAX_LSB +: 16];
    assign fcs_len = (fcs_on && s.ctrl[hrx_pkg::CTRL_XTRC]) ? (fcs32 ? 3'h4 : 3'h2) : 3'h0;
    assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;

    // whole datapath and register file next state
    always_comb begin
        n = s;
        n.out_v = 1'b0;
        d = rx_bit ^ (s.ctrl[hrx_pkg::CTRL_DSCR] & s.scr[42]);
        win = {s.hist[6:0], d};
        is_flag = 1'b0;
        is_seven = 1'b0;
        is_stuff = 1'b0;
        dbit_v = 1'b0;
        dbit = 1'b0;
        byte_v = 1'b0;
        byte_val = 8'h00;
        rel = 1'b0;
        rel_byte = 8'h00;
        rel_last = 1'b0;
        end_v = 1'b0;
        end_ab = 1'b0;
        inc_ab = 1'b0;
        inc_sz = 1'b0;
        inc_fcs = 1'b0;
        inc_good = 1'b0;
        // bit level: descramble, delineate, destuff
        if (rx_bit_valid) begin
            n.scr = {s.scr[41:0], rx_bit};
            if (cc) begin
                dbit_v = 1'b1;
                dbit = d;
            end else begin
                n.hist = win;
                n.ones = d ? ((s.ones == 3'h7) ? 3'h7 : s.ones + 3'h1) : 3'h0;
                n.gap = (s.gap >= hrx_pkg::GAP_MIN) ? s.gap : s.gap + 5'h01;
                is_flag = (win == hrx_pkg::FLAG_PAT);
                is_seven = d && (s.ones == 3'h6);
                is_stuff = !d && (s.ones == 3'h5);
                if (is_flag) begin
                    // every flag opens a new packet; it closes an open one only after the minimum gap, else drops it
                    n.st = hrx_pkg::HRX_OPEN;
                    n.gap = 5'h00;
                    n.dly_n = 3'h0;
                    n.nbit = 3'h0;
                    n.nbyte = 16'h0000;
                    n.crc = fcs32 ? 32'hffff_ffff : 32'h0000_ffff;
                    n.hold_n = 3'h0;
                    n.acc_n = 3'h0;
                    if (s.st == hrx_pkg::HRX_OPEN && s.gap >= hrx_pkg::GAP_MIN) begin
                        end_v = 1'b1;
                        if (s.nbit != 3'h0 || s.nbyte < min_len) begin
                            end_ab = 1'b1;
                            inc_sz = 1'b1;
                        end else if (fcs_on && (fcs32 ? (s.crc != hrx_pkg::CRC32_GOOD)
                                                      : (s.crc[15:0] != hrx_pkg::CRC16_GOOD))) begin
                            end_ab = 1'b1;
                            inc_fcs = 1'b1;
                        end else begin
                            inc_good = 1'b1;
                        end
                    end
                end else if (s.st == hrx_pkg::HRX_OPEN) begin
                    if (is_seven) begin
                        n.st = hrx_pkg::HRX_HUNT;
                        if (s.gap >= hrx_pkg::FILL_WIN) begin
                            end_v = 1'b1;
                            end_ab = 1'b1;
                            inc_ab = 1'b1;
                        end else begin
                            n.acc_n = 3'h0;
                        end
                    end else if (!is_stuff) begin
                        // seven-bit delay so flag bits never reach the packer
                        n.dly = {s.dly[5:0], d};
                        if (s.dly_n == hrx_pkg::DLY_N) begin
                            dbit_v = 1'b1;
                            dbit = s.dly[6];
                        end else begin
                            n.dly_n = s.dly_n + 3'h1;
                        end
                    end
                end
            end
        end
        // byte assembly and fcs accumulation
        if (dbit_v) begin
            if (!cc) begin
                n.crc = crc_step(s.crc, dbit, fcs32);
            end
            n.sh = s.ctrl[hrx_pkg::CTRL_REORD] ? {dbit, s.sh[7:1]} : {s.sh[6:0], dbit};
            n.nbit = s.nbit + 3'h1;
            if (s.nbit == 3'h7) begin
                byte_v = 1'b1;
                byte_val = n.sh;
                n.nbyte = s.nbyte + 16'h0001;
            end
        end
        // pseudo-packets or size check and fcs hold-back
        if (byte_v && cc) begin
            rel = 1'b1;
            rel_byte = byte_val;
            rel_last = (n.nbyte >= max_len);
            if (rel_last) begin
                n.nbyte = 16'h0000;
            end
        end else if (byte_v) begin
            if (n.nbyte > max_len) begin
                n.st = hrx_pkg::HRX_HUNT;
                end_v = 1'b1;
                end_ab = 1'b1;
                inc_sz = 1'b1;
            end else if (s.hold_n < fcs_len) begin
                n.hold = {s.hold[23:0], byte_val};
                n.hold_n = s.hold_n + 3'h1;
            end else begin
                rel = 1'b1;
                rel_byte = (fcs_len == 3'h4) ? s.hold[31:24] : (fcs_len == 3'h2) ? s.hold[15:8] : byte_val;
                n.hold = {s.hold[23:0], byte_val};
            end
        end
        // word packing, a full framed word waits for the next byte or the end; clear channel sends it at once
        if (rel) begin
            if (s.acc_n == 3'h4) begin
                n.out_v = 1'b1;
                n.out = '{data: s.acc, sop: s.sop_due, eop: 1'b0, abort: 1'b0, mod: 2'h3};
                n.sop_due = 1'b0;
                n.acc = {24'h00_0000, rel_byte};
                n.acc_n = 3'h1;
            end else begin
                n.acc[{s.acc_n[1:0], 3'h0} +: 8] = rel_byte;
                n.acc_n = s.acc_n + 3'h1;
                if (cc && (s.acc_n == 3'h3 || rel_last)) begin
                    n.out_v = 1'b1;
                    n.out = '{data: n.acc, sop: s.sop_due, eop: rel_last, abort: 1'b0, mod: s.acc_n[1:0]};
                    n.sop_due = rel_last;
                    n.acc_n = 3'h0;
                end
            end
        end
        if (end_v) begin
            if (s.acc_n != 3'h0) begin
                n.out_v = 1'b1;
                n.out = '{data: s.acc, sop: s.sop_due, eop: 1'b1, abort: end_ab, mod: 2'(s.acc_n - 3'h1)};
            end
            n.acc_n = 3'h0;
            n.sop_due = 1'b1;
        end
        if (is_flag) begin
            n.sop_due = 1'b1;
        end
        // register file
        hit = 1'b1;
        unique case (apb_req.paddr)
            hrx_pkg::ADDR_CTRL:  rd_mux = s.ctrl;
            hrx_pkg::ADDR_SIZE:  rd_mux = s.size;
            hrx_pkg::ADDR_STAT:  rd_mux = {31'h0, s.st == hrx_pkg::HRX_OPEN};
            hrx_pkg::ADDR_CABT:  rd_mux = 32'(cnt_ab);
            hrx_pkg::ADDR_CSIZ:  rd_mux = 32'(cnt_sz);
            hrx_pkg::ADDR_CFCS:  rd_mux = 32'(cnt_fcs);
            hrx_pkg::ADDR_CGOOD: rd_mux = 32'(cnt_good);
            default: begin
                rd_mux = 32'h0000_0000;
                hit = 1'b0;
            end
        endcase
        if (apb_req.psel && !apb_req.penable) begin
            n.rdata = rd_mux;
        end
        if (wr && apb_req.paddr == hrx_pkg::ADDR_CTRL) begin
            n.ctrl = apb_req.pwdata & hrx_pkg::CTRL_MASK;
        end
        if (wr && apb_req.paddr == hrx_pkg::ADDR_SIZE) begin
            n.size = apb_req.pwdata;
        end
    end

    // state register, cleared by reset except sop_due, ctrl and size
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s <= '0;
            s.sop_due <= 1'b1;
            s.ctrl <= hrx_pkg::CTRL_RST;
            s.size <= hrx_pkg::SIZE_RST;
        end else begin
            s <= n;
        end
    end

    // statistics counters, a write to the address clears
    hrx_sat_cnt #(.CNT_W(CNT_W)) u_cnt_ab (
        .clock (clock),
        .rst   (rst),
        .inc   (inc_ab),
        .clr   (wr && apb_req.paddr == hrx_pkg::ADDR_CABT),
        .count (cnt_ab)
    );
    hrx_sat_cnt #(.CNT_W(CNT_W)) u_cnt_sz (
        .clock (clock),
        .rst   (rst),
        .inc   (inc_sz),
        .clr   (wr && apb_req.paddr == hrx_pkg::ADDR_CSIZ),
        .count (cnt_sz)
    );
    hrx_sat_cnt #(.CNT_W(CNT_W)) u_cnt_fcs (
        .clock (clock),
        .rst   (rst),
        .inc   (inc_fcs),
        .clr   (wr && apb_req.paddr == hrx_pkg::ADDR_CFCS),
        .count (cnt_fcs)
    );
    hrx_sat_cnt #(.CNT_W(CNT_W)) u_cnt_good (
        .clock (clock),
        .rst   (rst),
        .inc   (inc_good),
        .clr   (wr && apb_req.paddr == hrx_pkg::ADDR_CGOOD),
        .count (cnt_good)
    );

    // outputs
    assign apb_rsp = '{prdata: s.rdata, pready: 1'b1, pslverr: apb_req.psel && apb_req.penable && !hit};
    assign rx_fifo_word = s.out;
    assign rx_fifo_valid = s.out_v;

    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    chk_scr_history: assert property (rx_bit_valid |=> s.scr[0] == $past(rx_bit))
        else $error("descrambler history missed a bit");
    chk_cc_pseudo_end: assert property (cc && rel_last |=> rx_fifo_valid && rx_fifo_word.eop && !rx_fifo_word.abort)
        else $error("pseudo-packet end not delivered");
    chk_flag_restart: assert property (rx_bit_valid && !cc && is_flag |=> s.st == hrx_pkg::HRX_OPEN && s.dly_n == 3'h0)
        else $error("flag did not restart the packet");
    chk_short_drop: assert property (rx_bit_valid && !cc && is_flag && s.gap < hrx_pkg::GAP_MIN |=> !rx_fifo_valid)
        else $error("short gap produced a word");
    chk_seven_hunt: assert property (rx_bit_valid && !cc && s.st == hrx_pkg::HRX_OPEN && is_seven && !is_flag
                                     |=> s.st == hrx_pkg::HRX_HUNT)
        else $error("seven ones did not stop the packet");
    chk_stuff_drop: assert property (rx_bit_valid && !cc && s.st == hrx_pkg::HRX_OPEN && is_stuff
                                     |=> s.dly == $past(s.dly) && s.nbit == $past(s.nbit))
        else $error("stuffed zero was kept");
    chk_mid_full: assert property (rx_fifo_valid && !rx_fifo_word.eop |-> rx_fifo_word.mod == 2'h3)
        else $error("mid-packet word not full");
    chk_abort_tag: assert property (end_v && end_ab && s.acc_n != 3'h0 |=> rx_fifo_valid && rx_fifo_word.abort)
        else $error("abort not tagged on last word");

    cov_good_pkt: cover property (rx_fifo_valid && rx_fifo_word.eop && !rx_fifo_word.abort);
    cov_fcs_err: cover property (inc_fcs);
    cov_abort: cover property (inc_ab);
    cov_cc_pkt: cover property (cc && rel_last);
endmodule
`default_nettype wire

// ---- dv/hrx_far_end.sv ----
// far-end model: scrambling serial bit source and receive fifo word sink
`default_nettype none
module hrx_far_end (
    // clock
    input  wire logic                  clock,
    // serial stream
    output logic                       rx_bit,
    output logic                       rx_bit_valid,
    // fifo side
    input  wire hrx_pkg::hrx_word_type rx_fifo_word,
    input  wire logic                  rx_fifo_valid
);
    timeunit 1ns;
    timeprecision 1ns;
    logic                  bitq[$];
    hrx_pkg::hrx_word_type got[$];
    logic [42:0]           scr_r;
    logic                  nb;
    bit                    scr;
    bit                    slow;
    bit                    gap;

    // line starts low with no valid bits until the bench queues bits
    initial begin
        rx_bit = 1'b0;
        rx_bit_valid = 1'b0;
        scr_r = '0;
    end

    // one bit a cycle, or every other cycle when slow; idle line keeps toggling
    always @(posedge clock) begin
        gap <= slow & ~gap;
        if (bitq.size() > 0 && !(slow && gap)) begin
            nb = bitq.pop_front() ^ (scr & scr_r[42]);
            scr_r <= {scr_r[41:0], nb};
            rx_bit <= nb;
            rx_bit_valid <= 1'b1;
        end else begin
            rx_bit <= ~rx_bit;
            rx_bit_valid <= 1'b0;
        end
        if (rx_fifo_valid === 1'b1) got.push_back(rx_fifo_word);
    end
endmodule
`default_nettype wire

// ---- dv/hrx_rx_proc_tb_top.sv ----
// testbench: registers, framed and clear-channel traffic through the receive processor
`default_nettype none
module hrx_rx_proc_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic                     clock;
    logic                     rst;
    logic                     rx_bit;
    logic                     rx_bit_valid;
    hrx_pkg::hrx_apb_req_type apb_req;
    hrx_pkg::hrx_apb_rsp_type apb_rsp;
    hrx_pkg::hrx_word_type    rx_fifo_word;
    logic                     rx_fifo_valid;
    hrx_pkg::hrx_word_type    w;
    int                       fail_count;
    int                       tests_run;
    logic [31:0]              ctrl;
    logic [31:0]              rd;
    logic                     err;
    logic [7:0]               dat[$];

    hrx_rx_proc #(.CNT_W(2)) hrx_rx_proc_i (.clock(clock), .rst(rst), .rx_bit(rx_bit),
        .rx_bit_valid(rx_bit_valid), .apb_req(apb_req), .apb_rsp(apb_rsp),
        .rx_fifo_word(rx_fifo_word), .rx_fifo_valid(rx_fifo_valid));
    hrx_far_end hrx_far_end_i (.clock(clock), .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid),
        .rx_fifo_word(rx_fifo_word), .rx_fifo_valid(rx_fifo_valid));

    // compare and count
    task automatic check(input string name, input logic [36:0] seen, input logic [36:0] exp);
        tests_run++;
        if (seen !== exp) begin
            $display("BAD %s expected %h seen %h", name, exp, seen);
            fail_count++;
        end
    endtask

    // counts, verdict, end of run
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // one apb transfer: setup, then access until pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge clock);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 50);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req <= '0;
        if (n >= 50) begin
            fail_count++;
            report_and_stop();
        end
        @(posedge clock);
    endtask

    // read and compare
    task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(name, {5'h00, rd}, {5'h00, e});
    endtask

    // write control and remember it
    task automatic cfg(input logic [31:0] c);
        ctrl = c;
        apb(1'b1, hrx_pkg::ADDR_CTRL, c);
    endtask

    // queue n bits, msb of the field first
    task automatic put(input logic [31:0] v, input int n);
        for (int k = n - 1; k >= 0; k--) hrx_far_end_i.bitq.push_back(v[k]);
    endtask

    // wait until the source has sent everything
    task automatic drain();
        int n;
        n = 0;
        while (hrx_far_end_i.bitq.size() > 0 && n < 5000) begin
            @(posedge clock);
            n++;
        end
        repeat (4) @(posedge clock);
        if (n >= 5000) begin
            fail_count++;
            report_and_stop();
        end
    endtask

    // build fcs, stuff, frame, send; then compare fifo words with the unstuffed bits
    task automatic frame(input logic bad, input logic shared, input logic ab, input logic ck);
        logic [31:0]           crc;
        logic [31:0]           mk;
        logic                  p[$];
        logic [7:0]            b;
        int                    ones;
        int                    nb;
        hrx_pkg::hrx_word_type e;
        crc = ctrl[3] ? 32'hffff_ffff : 32'h0000_ffff;
        e = '0;
        mk = '0;
        ones = 0;
        hrx_far_end_i.got.delete();
        foreach (dat[i]) for (int k = 7; k >= 0; k--) p.push_back(dat[i][k]);
        foreach (p[i]) crc = (crc >> 1) ^ ((crc[0] ^ p[i]) ? (ctrl[3] ? hrx_pkg::CRC32_POLY
            : {16'h0000, hrx_pkg::CRC16_POLY}) : 32'h0);
        for (int k = 0; k < (ctrl[3] ? 32 : 16); k++) p.push_back(~crc[k] ^ (bad && k == 0));
        put(32'h7e, 8);
        if (shared) put(32'h7e, 7);
        foreach (p[i]) begin
            hrx_far_end_i.bitq.push_back(p[i]);
            ones = p[i] ? ones + 1 : 0;
            if (ones == 5) begin
                put(32'h0, 1);
                ones = 0;
            end
        end
        put(32'h7eff, 16);
        drain();
        nb = p.size() / 8 - ((ctrl[2] && ctrl[4]) ? (ctrl[3] ? 4 : 2) : 0);
        if (ck) check("word count", hrx_far_end_i.got.size(), (nb + 3) / 4);
        for (int i = 0; i < nb && ck; i++) begin
            for (int k = 0; k < 8; k++) b[ctrl[5] ? k : 7 - k] = p[8 * i + k];
            e.data[8 * (i % 4) +: 8] = b;
            mk[8 * (i % 4) +: 8] = 8'hff;
            if (i % 4 == 3 || i == nb - 1) begin
                w = hrx_far_end_i.got[i / 4];
                w.data = w.data & mk;
                e.sop = (i < 4);
                e.eop = (i == nb - 1);
                e.abort = ab && e.eop;
                e.mod = e.eop ? 2'(i % 4) : 2'h3;
                check("fifo word", w, e);
                e = '0;
                mk = '0;
            end
        end
    endtask

    // 10 mhz clock
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // main sequence
    initial begin
        rst = 1'b1;
        apb_req = '0;
        fail_count = 0;
        tests_run = 0;
        ctrl = '0;
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rchk("ctrl reset", hrx_pkg::ADDR_CTRL, hrx_pkg::CTRL_RST);
        rchk("size reset", hrx_pkg::ADDR_SIZE, hrx_pkg::SIZE_RST);
        for (int a = 8; a <= 24; a += 4) rchk("status reset", 8'(a), 32'h0);
        apb(1'b1, 8'h1c, 32'h0000_00ff);
        check("unmapped error", err, 1'b1);
        rchk("unmapped read", 8'h1c, 32'h0);
        // fcs kept, then extracted and reordered with a slow source
        cfg(32'h0000_0004);
        dat = '{8'ha5, 8'h3e, 8'h7e, 8'hff};
        repeat (2) frame(1'b0, 1'b0, 1'b0, 1'b1);
        cfg(32'h0000_003c);
        hrx_far_end_i.slow = 1'b1;
        dat.push_back(8'h81);
        frame(1'b0, 1'b1, 1'b0, 1'b1);
        frame(1'b1, 1'b0, 1'b1, 1'b1);
        rchk("fcs errors", hrx_pkg::ADDR_CFCS, 32'h1);
        // scrambled line; good counter saturates, then clears
        hrx_far_end_i.slow = 1'b0;
        hrx_far_end_i.scr = 1'b1;
        cfg(32'h0000_0006);
        put(32'hffff_ffff, 32);
        put(32'hffff, 16);
        frame(1'b0, 1'b0, 1'b0, 1'b1);
        rchk("good saturated", hrx_pkg::ADDR_CGOOD, 32'h3);
        apb(1'b1, hrx_pkg::ADDR_CGOOD, 32'h0);
        rchk("good cleared", hrx_pkg::ADDR_CGOOD, 32'h0);
        hrx_far_end_i.scr = 1'b0;
        // fcs off: a bad fcs is neither checked nor removed
        cfg(32'h0000_0038);
        frame(1'b1, 1'b0, 1'b0, 1'b1);
        rchk("fcs off good", hrx_pkg::ADDR_CGOOD, 32'h1);
        rchk("fcs off quiet", hrx_pkg::ADDR_CFCS, 32'h1);
        // abort inside a packet, early ones after a flag, too-close flags
        cfg(32'h0000_0004);
        hrx_far_end_i.got.delete();
        put(32'h7e, 8);
        put(32'h0055_5555, 24);
        put(32'h7f, 7);
        put(32'h7eff, 16);
        drain();
        w = hrx_far_end_i.got[$];
        check("abort tag", w.abort, 1'b1);
        hrx_far_end_i.got.delete();
        put(32'h7efe, 16);
        put(32'h7e, 8);
        put(32'h2aa, 10);
        put(32'h7eff, 16);
        drain();
        check("dropped words", hrx_far_end_i.got.size(), 0);
        rchk("abort count", hrx_pkg::ADDR_CABT, 32'h1);
        rchk("size count", hrx_pkg::ADDR_CSIZ, 32'h0);
        // size limits include fcs; partial byte
        dat = '{8'h11, 8'h22};
        frame(1'b0, 1'b0, 1'b0, 1'b1);
        dat = '{8'h11};
        frame(1'b0, 1'b0, 1'b1, 1'b1);
        put(32'h7e, 8);
        put(32'h4_9249, 20);
        put(32'h7eff, 16);
        drain();
        rchk("partial byte", hrx_pkg::ADDR_CSIZ, 32'h2);
        apb(1'b1, hrx_pkg::ADDR_SIZE, 32'h0006_0004);
        dat = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
        frame(1'b0, 1'b0, 1'b1, 1'b0);
        check("long words", hrx_far_end_i.got.size(), 2);
        w = hrx_far_end_i.got[$];
        check("long abort", w.abort, 1'b1);
        rchk("long packet", hrx_pkg::ADDR_CSIZ, 32'h3);
        // clear channel: ones pass untouched in four-byte pseudo-packets
        cfg(32'h0000_0001);
        apb(1'b1, hrx_pkg::ADDR_SIZE, 32'h0004_0004);
        hrx_far_end_i.got.delete();
        repeat (3) put(32'hffff_ffff, 32);
        drain();
        check("cc words", hrx_far_end_i.got.size(), 3);
        foreach (hrx_far_end_i.got[i]) check("cc word", hrx_far_end_i.got[i], {32'hffff_ffff, 5'h1b});
        report_and_stop();
    end
endmodule
`default_nettype wire
